// >>> dam_alarm_monitor.sv
// DS1 receive alarm monitor: LOF/AIS integration, alarm status and AXI4-Lite registers
//
// Notes on behaviour
// R1: Status bit 1 flags AIS state change
// R2: Status bit 6 shows current AIS alarm
// R3: Flag each 6 ms interval holding LOF
// R4: Flagged intervals count up; 63 declares red
// R5: Clean intervals count down; zero removes red
// R6: Enable bit 2 gates red change interrupt
// R7: Block enable bit 1 gates all alarm interrupts
// R8: Software sets both enables for red interrupts
// R9: Declaring red sets bits 7 and 2
// R10: Clear-on-read mode clears on read, else write-clear
// R11: Red change bit holds until status read or write-cleared
// R12: Status bit 2 flags red state change
// R13: Status bit 7 shows red alarm declared
// R14: AIS detect: two frames, under three zeros
// R15: AIS flag needs 22 of 24 detections
// R16: AIS counter declares at 255, removes at zero
// R17: Enable bit 1 gates AIS change interrupt
// R18: Change bit set on declare and removal
// R19: Interrupt only for enabled, set change bits
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
module dam_alarm_monitor #(
  parameter int unsigned INTERVAL_CYCLES = dam_pkg::INTERVAL_CYCLES  // 6 ms interval length
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Receive framer side, same clock
  input wire logic i_lof,          // Loss of frame event
  input wire logic i_rx_valid,     // Received bit strobe
  input wire logic i_rx_data,      // Received bit value
  input wire logic i_rx_fbit,      // Bit is a framing bit
  input wire logic i_frame_sync,   // Frame boundary pulse
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [dam_pkg::ADDR_W-1:0] i_awaddr,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [dam_pkg::DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [dam_pkg::ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [dam_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  // Alarm outputs
  output logic o_irq,
  output logic o_red_alarm,
  output logic o_ais_alarm
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;  // First stage
  logic rst_n;         // Released copy used everywhere

  // Two stages so release is clean with respect to i_clk
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------
  localparam logic [dam_pkg::TMR_W-1:0] TMR_LAST = dam_pkg::TMR_W'(INTERVAL_CYCLES - 1);
  logic [dam_pkg::TMR_W-1:0] tmr_reg;  // Cycles into current interval
  wire tick = (tmr_reg == TMR_LAST);   // Last cycle of an interval [R3]

  // Free-running; intervals follow back to back
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tick ? '0 : tmr_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // LOF interval flag
  // ----------------------------------------------------------------
  logic lof_seen_reg;  // An LOF occurred in this interval
  wire red_flag = tick && lof_seen_reg;

  // An LOF on the tick cycle belongs to the next interval [R3]
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lof_seen_reg <= 1'b0;
    end else begin
      lof_seen_reg <= tick ? i_lof : (lof_seen_reg | i_lof);
    end
  end

  // ----------------------------------------------------------------
  // AIS detection over frame pairs
  // ----------------------------------------------------------------
  logic [1:0] pair_zeros_reg;               // Zeros in pair, saturating at limit
  logic second_frame_reg;                   // Current frame closes a pair
  logic [dam_pkg::DET_CNT_W-1:0] det_cnt_reg;  // Detections this interval
  wire zero_bit = i_rx_valid && !i_rx_data && !i_rx_fbit;  // Payload zero
  wire pair_end = i_frame_sync && second_frame_reg;
  wire ais_det = pair_end && (pair_zeros_reg < dam_pkg::AIS_ZERO_LIMIT);
  wire ais_flag = tick && (det_cnt_reg >= dam_pkg::AIS_DET_MIN);
  wire [1:0] zeros_inc = (pair_zeros_reg == dam_pkg::AIS_ZERO_LIMIT) ? pair_zeros_reg : pair_zeros_reg + 1'b1;
  wire det_sat = (det_cnt_reg == dam_pkg::DET_CNT_MAX);

  // Count payload zeros across two frames; a zero on the boundary opens the next pair [R14]
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pair_zeros_reg <= '0;
      second_frame_reg <= 1'b0;
    end else begin
      if (pair_end) begin
        pair_zeros_reg <= {1'b0, zero_bit};
      end else if (zero_bit) begin
        pair_zeros_reg <= zeros_inc;
      end
      if (i_frame_sync) begin
        second_frame_reg <= !second_frame_reg;
      end
    end
  end

  // Detections per interval; 22 or more posts the AIS flag at the tick [R14] [R15]
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_cnt_reg <= '0;
    end else if (tick) begin
      det_cnt_reg <= {{(dam_pkg::DET_CNT_W-1){1'b0}}, ais_det};
    end else if (ais_det && !det_sat) begin
      det_cnt_reg <= det_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Alarm integrators
  // ----------------------------------------------------------------
  logic red_alarm;
  logic red_change;
  logic ais_alarm;
  logic ais_change;

  // Red alarm: 63 flagged intervals declare, zero removes [R4] [R5]
  dam_flag_integrator #(.THRESHOLD(dam_pkg::RED_THRESHOLD)) u_red (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_tick(tick),
    .i_flag(red_flag),
    .o_alarm(red_alarm),
    .o_change(red_change),
    .o_count()
  );

  // AIS: 255 flagged intervals declare, zero removes [R16]
  dam_flag_integrator #(.THRESHOLD(dam_pkg::AIS_THRESHOLD)) u_ais (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_tick(tick),
    .i_flag(ais_flag),
    .o_alarm(ais_alarm),
    .o_change(ais_change),
    .o_count()
  );

  assign o_red_alarm = red_alarm;
  assign o_ais_alarm = ais_alarm;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_held_reg;                            // Address waiting for data
  logic [dam_pkg::ADDR_W-1:0] awaddr_reg;
  logic w_held_reg;                             // Data waiting for address
  logic [dam_pkg::DATA_W-1:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [dam_pkg::DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;

  assign o_awready = !aw_held_reg && !bvalid_reg;
  assign o_wready = !w_held_reg && !bvalid_reg;
  assign o_arready = !rvalid_reg;
  wire aw_hs = i_awvalid && o_awready;
  wire w_hs = i_wvalid && o_wready;
  wire ar_hs = i_arvalid && o_arready;
  wire do_write = (aw_held_reg || aw_hs) && (w_held_reg || w_hs);
  wire [dam_pkg::ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : i_awaddr;
  wire [dam_pkg::DATA_W-1:0] wr_data = w_held_reg ? wdata_reg : i_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : i_wstrb;
  wire [dam_pkg::IDX_W-1:0] wr_idx = wr_addr[dam_pkg::ADDR_W-1:2];
  wire [dam_pkg::IDX_W-1:0] rd_idx = i_araddr[dam_pkg::ADDR_W-1:2];
  // Only byte lane 0 holds register bits; other lanes are ignored
  wire wr_lane0 = do_write && wr_strb[0];
  wire [dam_pkg::REG_W-1:0] wr_byte = wr_data[dam_pkg::REG_W-1:0];

  // Write decode
  wire wr_hit_blk = wr_idx == dam_pkg::IDX_BLOCK_IRQ_ENABLE;
  wire wr_hit_sts = wr_idx == dam_pkg::IDX_ALARM_ERROR_STATUS;
  wire wr_hit_ien = wr_idx == dam_pkg::IDX_ALARM_ERROR_IRQ_ENABLE;
  wire wr_hit_ctl = wr_idx == dam_pkg::IDX_IRQ_CONTROL;
  wire wr_mapped = wr_hit_blk || wr_hit_sts || wr_hit_ien || wr_hit_ctl;
  // Read decode
  wire rd_hit_blk = rd_idx == dam_pkg::IDX_BLOCK_IRQ_ENABLE;
  wire rd_hit_sts = rd_idx == dam_pkg::IDX_ALARM_ERROR_STATUS;
  wire rd_hit_ien = rd_idx == dam_pkg::IDX_ALARM_ERROR_IRQ_ENABLE;
  wire rd_hit_ctl = rd_idx == dam_pkg::IDX_IRQ_CONTROL;
  wire rd_mapped = rd_hit_blk || rd_hit_sts || rd_hit_ien || rd_hit_ctl;

  // Hold whichever half arrives first; release both with the response
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= dam_pkg::RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? dam_pkg::RESP_OKAY : dam_pkg::RESP_SLVERR;
      end else begin
        if (aw_hs) begin
          aw_held_reg <= 1'b1;
          awaddr_reg <= i_awaddr;
        end
        if (w_hs) begin
          w_held_reg <= 1'b1;
          wdata_reg <= i_wdata;
          wstrb_reg <= i_wstrb;
        end
        if (bvalid_reg && i_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [dam_pkg::REG_W-1:0] blk_en_reg;   // block_irq_enable
  logic [dam_pkg::REG_W-1:0] irq_en_reg;   // alarm_error_irq_enable
  logic [dam_pkg::REG_W-1:0] ctl_reg;      // irq_control
  logic [dam_pkg::REG_W-1:0] chg_reg;      // Sticky change bits of alarm_error_status
  logic [dam_pkg::REG_W-1:0] chg_set;
  logic [dam_pkg::REG_W-1:0] status_word;
  wire clear_on_read = ctl_reg[dam_pkg::BIT_CLEAR_ON_READ];
  wire rd_clear = ar_hs && rd_hit_sts && clear_on_read;           // [R10]
  wire wr_clear = wr_lane0 && wr_hit_sts && !clear_on_read;       // [R10]
  wire [dam_pkg::REG_W-1:0] chg_clr = rd_clear ? dam_pkg::CHANGE_MASK :
                                      wr_clear ? (wr_byte & dam_pkg::CHANGE_MASK) : '0;

  // Change events and live states placed at their bit positions
  always_comb begin
    chg_set = '0;
    chg_set[dam_pkg::BIT_AIS_CHANGE] = ais_change;  // [R1] [R18]
    chg_set[dam_pkg::BIT_RED_CHANGE] = red_change;  // [R9] [R12] [R18]
    status_word = chg_reg;
    status_word[dam_pkg::BIT_AIS_STATE] = ais_alarm;  // [R2]
    status_word[dam_pkg::BIT_RED_STATE] = red_alarm;  // [R9] [R13]
  end

  // Register writes; a new event beats a clear in the same cycle [R11]
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_en_reg <= dam_pkg::RST_REG;
      irq_en_reg <= dam_pkg::RST_REG;
      ctl_reg <= dam_pkg::RST_REG;
      chg_reg <= dam_pkg::RST_REG;
    end else begin
      if (wr_lane0 && wr_hit_blk) begin
        blk_en_reg <= wr_byte & dam_pkg::BLOCK_EN_MASK;
      end
      if (wr_lane0 && wr_hit_ien) begin
        irq_en_reg <= wr_byte & dam_pkg::CHANGE_MASK;
      end
      if (wr_lane0 && wr_hit_ctl) begin
        ctl_reg <= wr_byte & dam_pkg::IRQ_CTRL_MASK;
      end
      chg_reg <= (chg_reg & ~chg_clr) | chg_set;  // [R10] [R11]
    end
  end

  // Read data: value before any clear this read causes
  wire [dam_pkg::REG_W-1:0] rd_byte = rd_hit_blk ? blk_en_reg :
                                      rd_hit_sts ? status_word :
                                      rd_hit_ien ? irq_en_reg :
                                      rd_hit_ctl ? ctl_reg : '0;

  // Read channel; rvalid holds until rready
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= dam_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {{(dam_pkg::DATA_W-dam_pkg::REG_W){1'b0}}, rd_byte};
      rresp_reg <= rd_mapped ? dam_pkg::RESP_OKAY : dam_pkg::RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // Block enable and any set change bit with its per-alarm enable must agree [R6] [R7] [R17] [R19]
  assign o_irq = blk_en_reg[dam_pkg::BIT_BLOCK_ALARM_EN] && ((chg_reg & irq_en_reg) != '0);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_lof_held;
    @(posedge i_clk) disable iff (!rst_n) (i_lof && !tick) |=> lof_seen_reg;
  endproperty
  a_lof_held: assert property (p_lof_held) else $error("LOF lost before interval end"); // [R3]

  property p_ais_det_counts;
    @(posedge i_clk) disable iff (!rst_n)
      (pair_end && pair_zeros_reg < dam_pkg::AIS_ZERO_LIMIT && !tick && !det_sat)
      |=> det_cnt_reg == $past(det_cnt_reg) + 1'b1;
  endproperty
  a_ais_det_counts: assert property (p_ais_det_counts) else $error("AIS detection not counted"); // [R14]

  property p_ais_flag;
    @(posedge i_clk) disable iff (!rst_n) (tick && det_cnt_reg < dam_pkg::AIS_DET_MIN) |=> !$rose(ais_alarm);
  endproperty
  a_ais_flag: assert property (p_ais_flag) else $error("AIS declared without a flag"); // [R15]

  sequence s_red_event;
    red_change;
  endsequence
  sequence s_red_posted;
    chg_reg[dam_pkg::BIT_RED_CHANGE] && (status_word[dam_pkg::BIT_RED_STATE] == !$past(red_alarm));
  endsequence
  property p_red_posted;
    @(posedge i_clk) disable iff (!rst_n) s_red_event |=> s_red_posted;
  endproperty
  a_red_posted: assert property (p_red_posted) else $error("red change not posted"); // [R9] [R12]

  property p_ais_posted;
    @(posedge i_clk) disable iff (!rst_n) ais_change |=> chg_reg[dam_pkg::BIT_AIS_CHANGE];
  endproperty
  a_ais_posted: assert property (p_ais_posted) else $error("AIS change not posted"); // [R1]

  property p_clear_on_read;
    @(posedge i_clk) disable iff (!rst_n) (rd_clear && !red_change) |=> !chg_reg[dam_pkg::BIT_RED_CHANGE];
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("read did not clear change bit"); // [R10]

  property p_change_holds;
    @(posedge i_clk) disable iff (!rst_n)
      (chg_reg[dam_pkg::BIT_RED_CHANGE] && !rd_clear && !wr_clear) |=> chg_reg[dam_pkg::BIT_RED_CHANGE];
  endproperty
  a_change_holds: assert property (p_change_holds) else $error("red change bit dropped"); // [R11]

  property p_block_gate;
    @(posedge i_clk) disable iff (!rst_n) !blk_en_reg[dam_pkg::BIT_BLOCK_ALARM_EN] |-> !o_irq;
  endproperty
  a_block_gate: assert property (p_block_gate) else $error("irq with block enable off"); // [R7]

  property p_alarm_gate;
    @(posedge i_clk) disable iff (!rst_n)
      (!irq_en_reg[dam_pkg::BIT_RED_CHANGE] && !irq_en_reg[dam_pkg::BIT_AIS_CHANGE]) |-> !o_irq;
  endproperty
  a_alarm_gate: assert property (p_alarm_gate) else $error("irq with alarm enables off"); // [R6] [R17] [R19]

  property p_state_read;
    @(posedge i_clk) disable iff (!rst_n)
      (ar_hs && rd_hit_sts) |=> (o_rdata[dam_pkg::BIT_RED_STATE] == $past(red_alarm))
                                && (o_rdata[dam_pkg::BIT_AIS_STATE] == $past(ais_alarm));
  endproperty
  a_state_read: assert property (p_state_read) else $error("status read shows wrong state"); // [R2] [R13]

endmodule // dam_alarm_monitor

// >>> dam_pkg.sv
// Shared constants for the DS1 receive alarm monitor
package dam_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;         // AXI4-Lite byte address width
  localparam int DATA_W = 32;         // AXI4-Lite data width
  localparam int IDX_W = 14;          // Word index width (byte address / 4)
  localparam int REG_W = 8;           // Implemented register width

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_BLOCK_IRQ_ENABLE = 14'h0b01;
  localparam logic [IDX_W-1:0] IDX_ALARM_ERROR_STATUS = 14'h0b02;
  localparam logic [IDX_W-1:0] IDX_ALARM_ERROR_IRQ_ENABLE = 14'h0b03;
  localparam logic [IDX_W-1:0] IDX_IRQ_CONTROL = 14'h0b04;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_AIS_CHANGE = 1;  // Status: AIS state changed
  localparam int BIT_RED_CHANGE = 2;  // Status: red alarm state changed
  localparam int BIT_AIS_STATE = 6;   // Status: AIS declared
  localparam int BIT_RED_STATE = 7;   // Status: red alarm declared
  localparam int BIT_BLOCK_ALARM_EN = 1;
  localparam int BIT_CLEAR_ON_READ = 0;

  // Writable / clearable bit masks and reset values
  localparam logic [REG_W-1:0] CHANGE_MASK = 8'h06;
  localparam logic [REG_W-1:0] BLOCK_EN_MASK = 8'h02;
  localparam logic [REG_W-1:0] IRQ_CTRL_MASK = 8'h01;
  localparam logic [REG_W-1:0] RST_REG = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int INTERVAL_MS = 6;
  localparam int NS_PER_MS = 1000000;
  localparam int INTERVAL_CYCLES = INTERVAL_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int TMR_W = 18;

  // ----------------------------------------------------------------
  // Integration thresholds
  // ----------------------------------------------------------------
  localparam int FLAG_CNT_W = 8;
  localparam logic [FLAG_CNT_W-1:0] RED_THRESHOLD = 8'h3f;  // 63 intervals
  localparam logic [FLAG_CNT_W-1:0] AIS_THRESHOLD = 8'hff;  // 255 intervals
  localparam logic [FLAG_CNT_W-1:0] CNT_ONE = 8'h01;
  localparam int DET_CNT_W = 5;
  localparam logic [DET_CNT_W-1:0] AIS_DET_MIN = 5'h16;     // 22 detections
  localparam logic [DET_CNT_W-1:0] DET_CNT_MAX = 5'h1f;
  localparam logic [1:0] AIS_ZERO_LIMIT = 2'h3;             // Fewer than 3 zeros

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> dam_flag_integrator.sv
// Up/down interval flag counter that declares and removes one alarm
`timescale 1ns/10ps
module dam_flag_integrator #(
  parameter logic [dam_pkg::FLAG_CNT_W-1:0] THRESHOLD = dam_pkg::RED_THRESHOLD
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Interval events
  input wire logic i_tick,
  input wire logic i_flag,
  // Alarm outputs
  output logic o_alarm,
  output logic o_change,
  output logic [dam_pkg::FLAG_CNT_W-1:0] o_count
);

  // ----------------------------------------------------------------
  // Counter and alarm state
  // ----------------------------------------------------------------
  localparam logic [dam_pkg::FLAG_CNT_W-1:0] ONE_BELOW = THRESHOLD - dam_pkg::CNT_ONE;
  logic [dam_pkg::FLAG_CNT_W-1:0] cnt_reg;   // Flag counter
  logic [dam_pkg::FLAG_CNT_W-1:0] cnt_next;
  logic alarm_reg;                           // Declared alarm
  logic alarm_next;
  wire step_up = i_tick && i_flag && (cnt_reg != THRESHOLD);          // Saturates at threshold
  wire step_dn = i_tick && !i_flag && (cnt_reg != '0);                // Stops at zero

  // Count flagged intervals up, clean ones down [R4] [R5]
  assign cnt_next = step_up ? cnt_reg + dam_pkg::CNT_ONE :
                    step_dn ? cnt_reg - dam_pkg::CNT_ONE : cnt_reg;
  // Declare on reaching threshold, remove only on reaching zero [R4] [R5] [R16]
  assign alarm_next = (step_up && cnt_reg == ONE_BELOW) ? 1'b1 :
                      (step_dn && cnt_reg == dam_pkg::CNT_ONE) ? 1'b0 : alarm_reg;
  // Change pulse on both declare and removal [R18]
  assign o_change = alarm_next ^ alarm_reg;
  assign o_alarm = alarm_reg;
  assign o_count = cnt_reg;

  // State registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      alarm_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      alarm_reg <= alarm_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_declare_at_threshold;
    @(posedge i_clk) disable iff (!i_rst_n) $rose(alarm_reg) |-> cnt_reg == THRESHOLD;
  endproperty
  a_declare_at_threshold: assert property (p_declare_at_threshold) else $error("alarm rose below threshold"); // [R4] [R16]

  property p_remove_at_zero;
    @(posedge i_clk) disable iff (!i_rst_n) $fell(alarm_reg) |-> cnt_reg == '0;
  endproperty
  a_remove_at_zero: assert property (p_remove_at_zero) else $error("alarm fell with nonzero count"); // [R5] [R16]

  property p_step_up;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_tick && i_flag && cnt_reg != THRESHOLD) |=> cnt_reg == $past(cnt_reg) + dam_pkg::CNT_ONE;
  endproperty
  a_step_up: assert property (p_step_up) else $error("flagged interval did not count up"); // [R4]

  property p_change_pulse;
    @(posedge i_clk) disable iff (!i_rst_n) o_change |=> alarm_reg != $past(alarm_reg);
  endproperty
  a_change_pulse: assert property (p_change_pulse) else $error("change pulse without state change"); // [R18]

endmodule // dam_flag_integrator

// >>> dam_line_model.sv
// Partner model: remote DS1 terminal line feeding the framer side
`timescale 1ns/10ps
module dam_line_model (
  // Clock and controls
  input wire logic i_clk,
  input wire logic i_lof_on,
  input wire logic i_ais_on,   // Send all ones instead of all zeros
  // Framer-side outputs
  output logic o_lof,
  output logic o_rx_valid,
  output logic o_rx_data,
  output logic o_rx_fbit,
  output logic o_frame_sync
);
  logic [1:0] bit_reg = 2'h0; // Three-bit frames so a pair fits in six cycles
  always_ff @(posedge i_clk) begin
    bit_reg <= (bit_reg == 2'h2) ? 2'h0 : bit_reg + 2'h1;
  end
  assign o_lof = i_lof_on;
  assign o_rx_valid = 1'b1;
  assign o_rx_fbit = (bit_reg == 2'h0);
  assign o_rx_data = i_ais_on; // All zeros give four per pair, so no AIS detection
  assign o_frame_sync = (bit_reg == 2'h2);
endmodule // dam_line_model

// >>> dam_alarm_monitor_tb.sv
// Self-checking bench for the DS1 receive alarm monitor
`timescale 1ns/10ps
module dam_alarm_monitor_tb;
  localparam int IVL = 138; // Shortened interval, still 23 frame pairs long
  localparam logic [15:0] AB = 16'h2c04, AS = 16'h2c08, AE = 16'h2c0c, AC = 16'h2c10;
  logic i_clk = 1'b0, i_nrst = 1'b0, lof = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic aon = 1'b0; // Line sends AIS
  logic [15:0] awa = 16'h0000, ara = 16'h0000;
  logic [31:0] wd = 32'h0000_0000, rd, rdat, x = 32'h0000_0011;
  logic [1:0] rs, bresp, rresp;
  logic awr, wrdy, bv, arr, rv, irq, red, ais, lo, lv, ld, lf, ls;
  int n_fail = 0, comparisons = 0, cyc = 0;
  always #12.5 i_clk = ~i_clk;
  // Hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end
  dam_line_model dam_line_model_inst (.i_clk(i_clk), .i_lof_on(lof), .o_lof(lo), .o_rx_valid(lv),
    .i_ais_on(aon), .o_rx_data(ld), .o_rx_fbit(lf), .o_frame_sync(ls));
  dam_alarm_monitor #(.INTERVAL_CYCLES(IVL)) dam_alarm_monitor_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_lof(lo),
    .i_rx_valid(lv), .i_rx_data(ld), .i_rx_fbit(lf), .i_frame_sync(ls), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wd), .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(br),
    .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(rr),
    .o_rdata(rdat), .o_rresp(rresp), .o_irq(irq), .o_red_alarm(red), .o_ais_alarm(ais));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Reference model of the red integrator, compared at every edge once reset is out
  int mt = 0, mc = 0, ms = 0;
  logic mseen = 1'b0, mred = 1'b0;
  always @(posedge i_clk) begin
    if (ms < 2) begin
      ms = ms + int'(i_nrst);
    end else begin
      chk(red, mred);
      if (mt == IVL - 1) begin
        mc = mseen ? (mc < 63 ? mc + 1 : mc) : (mc > 0 ? mc - 1 : 0);
        if (mc == 63) mred = 1'b1;
        else if (mc == 0) mred = 1'b0;
        mseen = lo;
        mt = 0;
      end else begin
        mseen = mseen | lo;
        mt++;
      end
    end
  end
  // Write: both halves offered together, each dropped once taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {awv, wv, br} <= 3'b111;
    awa <= a;
    wd <= d;
    do begin
      @(posedge i_clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    rs = bresp;
    br <= 1'b0;
  endtask
  task automatic rdr(input logic [15:0] a);
    @(posedge i_clk);
    {arv, rr} <= 2'b11;
    ara <= a;
    do begin
      @(posedge i_clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    {rs, rd} = {rresp, rdat};
    rr <= 1'b0;
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    for (int i = 0; i < 3; i++) begin
      rdr(AB + 16'(4 * i));
      chk(rd, 0);
    end
    for (int i = 0; i < 4; i++) begin
      x = xs(x);
      wr(AB, x);
      rdr(AB);
      chk(rd, x & 32'h2);
      x = xs(x);
      wr(AE, x);
      rdr(AE);
      chk(rd, x & 32'h6);
    end
    // Unmapped word: error answer, write dropped, read zero
    wr(16'h0000, x);
    chk(rs, 2'h2);
    rdr(16'h0000);
    chk({rs, rd}, {2'h2, 32'h0});
    wr(AB, 32'h2);
    wr(AE, 32'h4);
    lof <= 1'b1;
    repeat (62 * IVL - 5) @(posedge i_clk);
    chk({irq, red}, 0);
    repeat (4 * IVL) @(posedge i_clk);
    rdr(AS);
    chk({irq, red, ais, rd}, {3'b110, 32'h84});
    wr(AE, 32'h2);
    chk(irq, 0);
    wr(AE, 32'h4);
    wr(AB, 32'h0);
    chk(irq, 0);
    wr(AB, 32'h2);
    chk(irq, 1);
    wr(AS, 32'h4);
    rdr(AS);
    chk({irq, rd}, {1'b0, 32'h80});
    lof <= 1'b0;
    repeat (60 * IVL) @(posedge i_clk);
    chk(red, 1);
    repeat (6 * IVL) @(posedge i_clk);
    rdr(AS);
    chk({irq, red, rd}, {2'b10, 32'h04});
    wr(AC, 32'h1);
    rdr(AS);
    chk(rd, 32'h04);
    rdr(AS);
    chk({irq, rd}, 0);
    // AIS: all-ones payload, 255 flagged intervals declare
    aon <= 1'b1;
    repeat (253 * IVL) @(posedge i_clk);
    chk(ais, 0);
    repeat (5 * IVL) @(posedge i_clk);
    chk({ais, irq}, 2'b10);
    wr(AE, 32'h2);
    chk(irq, 1);
    rdr(AS);
    chk({irq, rd}, {1'b0, 32'h42});
    report_and_stop();
  end
endmodule // dam_alarm_monitor_tb
